// *** sld_pkg.sv ***
// Function
// - with diagnostics enabled, classify each channel's load and detect booster or shorts.
// - a detected booster lets the amplifier start in line driver, low gain mode.
// - first stage applies offset, raises it after 15 ms, reduces it after the 10 ms measurement, removes it 15 ms later.
// - any output above 3.5 V during the first stage aborts the diagnostic sequence.
// - an invalid supply at the capture makes every channel report the invalid load code after the first stage.
// - starting a cycle sets invalid codes and raises the diagnostics busy flag.
// - busy flag clears when the sequence completes or power-on reset interrupts it.
// - diagnostics without amplifier start: clear busy, update status, do not start amplifier.
// - in diagnostics-only use, toggling the enable restarts the sequence with invalid codes, busy.
// - with amplifier start, start amplifier after cycle; clear busy just before mute release.
// - load code 00 normal, 01 line driver, 10 open, 11 invalid.
// - status byte bit3 shorted load, bit1 short to supply, bit0 short to ground.
// - an engine start during measurement sets affected channels' load code to 11.
// - view select zero shows stored results; one hides them but keeps them.
// - short flags clear after each bus read and set again only while the short persists.
// - load code bits change only when a new diagnostic cycle runs.
// - a bus read of the offset status sets the per-channel offset latches.
// - bridge output inside the 1.3 V window clears the latch until the next read.
package sld_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLOCK_KHZ      = 200_000;
   localparam int unsigned RAMP_MS        = 15;
   localparam int unsigned RAMP_CYCLES    = RAMP_MS * CLOCK_KHZ;
   localparam int unsigned MEASURE_MS     = 10;
   localparam int unsigned MEASURE_CYCLES = MEASURE_MS * CLOCK_KHZ;
   localparam int unsigned COUNT_W        = 24;

   // ---------------------------------------------------------------
   // channel status byte layout
   // ---------------------------------------------------------------
   localparam int unsigned NUM_CHANNELS   = 4;
   localparam int unsigned BIT_GROUND     = 0;
   localparam int unsigned BIT_SUPPLY     = 1;
   localparam int unsigned BIT_OFFSET     = 2;
   localparam int unsigned BIT_SHORTED    = 3;
   localparam int unsigned BIT_CODE_LO    = 4;
   localparam int unsigned BIT_CODE_HI    = 5;
   localparam logic [7:0]  STATUS_RESET   = 8'h30;

   // ---------------------------------------------------------------
   // load codes and offset drive levels
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CODE_NORMAL  = 2'b00,
      CODE_LINEDRV = 2'b01,
      CODE_OPEN    = 2'b10,
      CODE_INVALID = 2'b11
   } sld_code_t;

   localparam logic [1:0] LEVEL_OFF  = 2'h0;
   localparam logic [1:0] LEVEL_LOW  = 2'h1;
   localparam logic [1:0] LEVEL_HIGH = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_RAMP_UP   = 3'b001,
      ST_MEASURE   = 3'b010,
      ST_RAMP_DOWN = 3'b011,
      ST_AMP_START = 3'b100
   } sld_state_t;
endpackage

// *** sld_chan_if.sv ***
`timescale 1ns/1ps
interface sld_chan_if;
   logic startCycle;
   logic measuring;
   logic capture;
   logic busRead;
   logic viewAc;
   logic supplyInvalid;
   modport ctl  (output startCycle, measuring, capture, busRead, viewAc, supplyInvalid);
   modport chan (input  startCycle, measuring, capture, busRead, viewAc, supplyInvalid);
endinterface

// *** sld_channel.sv ***
`timescale 1ns/1ps
module sld_channel (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // sequencing from the controller
   sld_chan_if.chan        ctl,
   // channel sense inputs
   input  wire logic       outputHigh,
   input  wire logic       engineDisturb,
   input  wire logic       openSense,
   input  wire logic       boosterSense,
   input  wire logic       shortedSense,
   input  wire logic       supplySense,
   input  wire logic       groundSense,
   input  wire logic       inWindow,
   // status byte
   output logic [7:0]      statusByte
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [1:0] code_reg,     code_next;
   logic       shorted_reg,  shorted_next;
   logic       supply_reg,   supply_next;
   logic       ground_reg,   ground_next;
   logic       offset_reg,   offset_next;
   logic       hit_reg,      hit_next;
   logic       disturb_reg,  disturb_next;
   logic [7:0] status_reg,   status_next;
   logic [1:0] measuredCode;
   logic       badMeasure;

   // ---------------------------------------------------------------
   // load code
   // ---------------------------------------------------------------
   assign hit_next     = ctl.startCycle ? 1'b0 : (hit_reg | (ctl.measuring & outputHigh));
   assign disturb_next = ctl.startCycle ? 1'b0
                       : (disturb_reg | (ctl.measuring & engineDisturb));
   assign badMeasure   = hit_reg | disturb_reg | ctl.supplyInvalid;
   assign measuredCode = badMeasure   ? sld_pkg::CODE_INVALID
                       : boosterSense ? sld_pkg::CODE_LINEDRV
                       : openSense    ? sld_pkg::CODE_OPEN
                       : sld_pkg::CODE_NORMAL;
   assign code_next    = ctl.startCycle ? sld_pkg::CODE_INVALID
                       : ctl.capture    ? measuredCode
                       : code_reg;

   // ---------------------------------------------------------------
   // short flags: a set beats the clear by a read; offset flag: the set by a read beats the window clear
   // ---------------------------------------------------------------
   assign shorted_next = shortedSense | (shorted_reg & ~ctl.busRead);
   assign supply_next  = supplySense  | (supply_reg  & ~ctl.busRead);
   assign ground_next  = groundSense  | (ground_reg  & ~ctl.busRead);
   assign offset_next  = ctl.busRead ? 1'b1 : (inWindow ? 1'b0 : offset_reg);

   // ---------------------------------------------------------------
   // visible byte; stored code hidden under the alternate view
   // ---------------------------------------------------------------
   assign status_next = {2'b00,
                         ctl.viewAc ? 2'b00 : code_next,
                         shorted_next, offset_next, supply_next, ground_next};

   always_ff @(posedge clock) begin
      if (reset) begin
         code_reg    <= sld_pkg::CODE_INVALID;
         shorted_reg <= 1'b0;
         supply_reg  <= 1'b0;
         ground_reg  <= 1'b0;
         offset_reg  <= 1'b0;
         hit_reg     <= 1'b0;
         disturb_reg <= 1'b0;
         status_reg  <= sld_pkg::STATUS_RESET;
      end else begin
         code_reg    <= code_next;
         shorted_reg <= shorted_next;
         supply_reg  <= supply_next;
         ground_reg  <= ground_next;
         offset_reg  <= offset_next;
         hit_reg     <= hit_next;
         disturb_reg <= disturb_next;
         status_reg  <= status_next;
      end
   end

   assign statusByte = status_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   start_code_invalid_a: assert property (
      ctl.startCycle |=> code_reg == sld_pkg::CODE_INVALID)
      else $error("load code not invalid after cycle start");
   code_hold_a: assert property (
      !ctl.startCycle && !ctl.capture |=> $stable(code_reg))
      else $error("load code changed outside a cycle");
   disturb_invalid_a: assert property (
      ctl.capture && disturb_reg |=> code_reg == sld_pkg::CODE_INVALID)
      else $error("disturbed channel not invalid");
   read_clears_short_a: assert property (
      ctl.busRead && !shortedSense |=> !shorted_reg)
      else $error("shorted flag survived a read");
   read_sets_offset_a: assert property (
      ctl.busRead |=> offset_reg ##1 (offset_reg || $past(inWindow)))
      else $error("offset latch not set by read");
   window_blocks_offset_a: assert property (
      !ctl.busRead && inWindow |=> !offset_reg)
      else $error("offset latch not cleared in window");
   view_hides_code_a: assert property (
      ctl.viewAc |=> statusByte[sld_pkg::BIT_CODE_HI:sld_pkg::BIT_CODE_LO] == 2'b00)
      else $error("code visible under alternate view");

   open_seen_c: cover property (ctl.capture && openSense && !badMeasure);
   offset_cycle_c: cover property (ctl.busRead ##[1:20] inWindow);
endmodule

// *** sld_startup_diag.sv ***
`timescale 1ns/1ps
module sld_startup_diag #(
   parameter int unsigned RAMP_CYCLES    = sld_pkg::RAMP_CYCLES,
   parameter int unsigned MEASURE_CYCLES = sld_pkg::MEASURE_CYCLES
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // control bits
   input  wire logic       diagEnableBit,
   input  wire logic       ampStartEnableBit,
   input  wire logic       resultViewSelect,
   input  wire logic       statusRead,
   // analog condition inputs
   input  wire logic       supplyInvalid,
   input  wire logic       ampStartupDone,
   input  wire logic [3:0] outputHigh,
   input  wire logic [3:0] engineDisturb,
   input  wire logic [3:0] openSense,
   input  wire logic [3:0] boosterSense,
   input  wire logic [3:0] shortedSense,
   input  wire logic [3:0] supplySense,
   input  wire logic [3:0] groundSense,
   input  wire logic [3:0] bridgeInWindow,
   // status and drive outputs
   output logic            diagBusyFlag,
   output logic            diagAborted,
   output logic [1:0]      diagOffsetLevel,
   output logic            ampStartRequest,
   output logic            lineDriverMode,
   output logic [3:0][7:0] channelStatusByte
);
   localparam logic [sld_pkg::COUNT_W-1:0] RAMP_LAST    =
      sld_pkg::COUNT_W'(RAMP_CYCLES - 1);
   localparam logic [sld_pkg::COUNT_W-1:0] MEASURE_LAST =
      sld_pkg::COUNT_W'(MEASURE_CYCLES - 1);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   sld_pkg::sld_state_t              state_reg,   state_next;
   logic [sld_pkg::COUNT_W-1:0]      count_reg,   count_next;
   logic                             busy_reg,    busy_next;
   logic                             abort_reg,   abort_next;
   logic [1:0]                       level_reg,   level_next;
   logic                             amp_reg,     amp_next;
   logic                             lineDrv_reg, lineDrv_next;
   logic                             diagPrev_reg;
   logic                             ampPrev_reg;

   sld_chan_if chanBus ();

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic diagRise;
   logic ampRise;
   logic startReq;
   logic anyHigh;
   logic rampDone;
   logic measureDone;
   logic firstStage;
   logic finishing;
   logic anyBooster;

   assign diagRise    = diagEnableBit & ~diagPrev_reg;
   assign ampRise     = ampStartEnableBit & ~ampPrev_reg & diagEnableBit;
   assign startReq    = (state_reg == sld_pkg::ST_IDLE) & (diagRise | ampRise);
   assign anyHigh     = |outputHigh;
   assign rampDone    = count_reg == RAMP_LAST;
   assign measureDone = count_reg == MEASURE_LAST;
   assign firstStage  = (state_reg == sld_pkg::ST_RAMP_UP) |
                        (state_reg == sld_pkg::ST_MEASURE);
   assign finishing   = (state_reg == sld_pkg::ST_RAMP_DOWN) & rampDone;
   assign anyBooster  = |boosterSense;

   assign chanBus.startCycle    = startReq;
   assign chanBus.measuring     = firstStage;
   assign chanBus.capture       = (state_reg == sld_pkg::ST_MEASURE) & measureDone
                                & ~anyHigh;
   assign chanBus.busRead       = statusRead;
   assign chanBus.viewAc        = resultViewSelect;
   assign chanBus.supplyInvalid = supplyInvalid;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next   = state_reg;
      count_next   = count_reg + 1'b1;
      busy_next    = busy_reg;
      abort_next   = abort_reg;
      level_next   = level_reg;
      lineDrv_next = lineDrv_reg;
      unique case (state_reg)
         sld_pkg::ST_IDLE: begin
            count_next = '0;
            if (startReq) begin
               state_next   = sld_pkg::ST_RAMP_UP;
               busy_next    = 1'b1;
               abort_next   = 1'b0;
               lineDrv_next = 1'b0;
               level_next   = sld_pkg::LEVEL_LOW;
            end
         end
         sld_pkg::ST_RAMP_UP: begin
            if (anyHigh) begin
               state_next = sld_pkg::ST_RAMP_DOWN;
               abort_next = 1'b1;
               count_next = '0;
            end else if (rampDone) begin
               state_next = sld_pkg::ST_MEASURE;
               level_next = sld_pkg::LEVEL_HIGH;
               count_next = '0;
            end
         end
         sld_pkg::ST_MEASURE: begin
            if (anyHigh) begin
               state_next = sld_pkg::ST_RAMP_DOWN;
               abort_next = 1'b1;
               level_next = sld_pkg::LEVEL_LOW;
               count_next = '0;
            end else if (measureDone) begin
               state_next   = sld_pkg::ST_RAMP_DOWN;
               level_next   = sld_pkg::LEVEL_LOW;
               lineDrv_next = anyBooster;
               count_next   = '0;
            end
         end
         sld_pkg::ST_RAMP_DOWN: begin
            if (rampDone) begin
               level_next = sld_pkg::LEVEL_OFF;
               count_next = '0;
               if (ampStartEnableBit && !abort_reg) begin
                  state_next = sld_pkg::ST_AMP_START;
               end else begin
                  state_next = sld_pkg::ST_IDLE;
                  busy_next  = 1'b0;
               end
            end
         end
         sld_pkg::ST_AMP_START: begin
            count_next = '0;
            if (ampStartupDone || !ampStartEnableBit) begin
               state_next = sld_pkg::ST_IDLE;
               busy_next  = 1'b0;
            end
         end
         default: begin
            state_next = sld_pkg::ST_IDLE;
            busy_next  = 1'b0;
            level_next = sld_pkg::LEVEL_OFF;
         end
      endcase
   end

   // amplifier runs only once diagnostics have released it, or with diagnostics off
   assign amp_next = ampStartEnableBit &
                     ((state_next == sld_pkg::ST_AMP_START) |
                      (state_next == sld_pkg::ST_IDLE & (amp_reg | ~diagEnableBit)));

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg    <= sld_pkg::ST_IDLE;
         count_reg    <= '0;
         busy_reg     <= 1'b0;
         abort_reg    <= 1'b0;
         level_reg    <= sld_pkg::LEVEL_OFF;
         amp_reg      <= 1'b0;
         lineDrv_reg  <= 1'b0;
         diagPrev_reg <= 1'b0;
         ampPrev_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         count_reg    <= count_next;
         busy_reg     <= busy_next;
         abort_reg    <= abort_next;
         level_reg    <= level_next;
         amp_reg      <= amp_next;
         lineDrv_reg  <= lineDrv_next;
         diagPrev_reg <= diagEnableBit;
         ampPrev_reg  <= ampStartEnableBit;
      end
   end

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   for (genvar ch = 0; ch < sld_pkg::NUM_CHANNELS; ch++) begin : gChan
      sld_channel uChan (
         .clock         (clock),
         .reset         (reset),
         .ctl           (chanBus),
         .outputHigh    (outputHigh[ch]),
         .engineDisturb (engineDisturb[ch]),
         .openSense     (openSense[ch]),
         .boosterSense  (boosterSense[ch]),
         .shortedSense  (shortedSense[ch]),
         .supplySense   (supplySense[ch]),
         .groundSense   (groundSense[ch]),
         .inWindow      (bridgeInWindow[ch]),
         .statusByte    (channelStatusByte[ch])
      );
   end

   assign diagBusyFlag    = busy_reg;
   assign diagAborted     = abort_reg;
   assign diagOffsetLevel = level_reg;
   assign ampStartRequest = amp_reg;
   assign lineDriverMode  = lineDrv_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   start_sets_busy_a: assert property (
      startReq |=> diagBusyFlag && diagOffsetLevel == sld_pkg::LEVEL_LOW)
      else $error("busy or offset not raised at cycle start");
   overvolt_abort_a: assert property (
      firstStage && anyHigh |=> state_reg == sld_pkg::ST_RAMP_DOWN && diagAborted)
      else $error("first stage not aborted on high output");
   ramp_up_time_a: assert property (
      state_reg == sld_pkg::ST_RAMP_UP && rampDone && !anyHigh
      |=> diagOffsetLevel == sld_pkg::LEVEL_HIGH)
      else $error("offset not raised after ramp time");
   ramp_down_end_a: assert property (
      finishing |=> diagOffsetLevel == sld_pkg::LEVEL_OFF)
      else $error("offset not removed after ramp down");
   diag_only_done_a: assert property (
      finishing && !ampStartEnableBit |=> !diagBusyFlag ##1 !ampStartRequest)
      else $error("diagnostics-only end wrong");
   amp_before_busy_a: assert property (
      state_reg == sld_pkg::ST_AMP_START && ampStartEnableBit
      |-> ampStartRequest && diagBusyFlag)
      else $error("amplifier not started while busy");
   busy_cleared_a: assert property (
      state_reg == sld_pkg::ST_AMP_START && ampStartupDone |=> !diagBusyFlag)
      else $error("busy not cleared at mute release");
   busy_idle_a: assert property (
      state_reg == sld_pkg::ST_IDLE && !startReq |=> !diagBusyFlag)
      else $error("busy stuck while idle");

   // ---------------------------------------------------------------
   // sequence checks
   // ---------------------------------------------------------------
   start_clears_abort_a: assert property (
      startReq |=> !diagAborted)
      else $error("abort flag kept into new cycle");

   busy_in_cycle_a: assert property (
      state_reg != sld_pkg::ST_IDLE |-> diagBusyFlag)
      else $error("busy low during a cycle");

   idle_level_off_a: assert property (
      state_reg == sld_pkg::ST_IDLE
      |-> diagOffsetLevel == sld_pkg::LEVEL_OFF)
      else $error("offset driven while idle");

   measure_level_a: assert property (
      state_reg == sld_pkg::ST_MEASURE
      |-> diagOffsetLevel == sld_pkg::LEVEL_HIGH)
      else $error("offset not high while measuring");

   measure_end_a: assert property (
      state_reg == sld_pkg::ST_MEASURE && measureDone && !anyHigh
      |=> diagOffsetLevel == sld_pkg::LEVEL_LOW)
      else $error("offset not lowered after measuring");

   booster_mode_a: assert property (
      state_reg == sld_pkg::ST_MEASURE && measureDone && !anyHigh
      |=> lineDriverMode == $past(anyBooster))
      else $error("line driver mode not taken from booster");

   ramp_count_a: assert property (
      state_reg == sld_pkg::ST_RAMP_UP |-> count_reg <= RAMP_LAST)
      else $error("ramp counter overran");

   no_amp_in_cycle_a: assert property (
      firstStage |-> !ampStartRequest)
      else $error("amplifier running during measurement");

   abort_no_amp_a: assert property (
      finishing && diagAborted && diagEnableBit
      |=> !ampStartRequest)
      else $error("amplifier started after abort");

   amp_after_cycle_a: assert property (
      finishing && !diagAborted && ampStartEnableBit
      |=> state_reg == sld_pkg::ST_AMP_START && ampStartRequest)
      else $error("amplifier not started after cycle");

   amp_direct_a: assert property (
      state_reg == sld_pkg::ST_IDLE && !startReq && !diagEnableBit
      |=> ampStartRequest == $past(ampStartEnableBit))
      else $error("amplifier not following start bit");

   full_cycle_c: cover property (finishing && !diagAborted);
   abort_c: cover property (firstStage && anyHigh);
   amp_start_c: cover property (state_reg == sld_pkg::ST_AMP_START && ampStartupDone);
endmodule

// *** sld_host_model.sv ***
`timescale 1ns/1ps
module sld_host_model (
   // clock
   input  wire logic clock,
   // device status
   input  wire logic diagBusyFlag,
   input  wire logic ampStartRequest,
   // control bits
   output logic      diagEnableBit,
   output logic      ampStartEnableBit,
   output logic      statusRead
);
   initial begin
      diagEnableBit = 1'b0;
      ampStartEnableBit = 1'b0;
      statusRead = 1'b0;
   end
   task automatic set_bits(input logic d, input logic a);
      @(posedge clock);
      diagEnableBit <= d;
      ampStartEnableBit <= a;
   endtask
   // one-cycle bus read of the status bytes
   task automatic bus_read();
      @(posedge clock);
      statusRead <= 1'b1;
      @(posedge clock);
      statusRead <= 1'b0;
   endtask
   // a new cycle is only allowed once busy and the amplifier are both off
   task automatic wait_idle(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 200 && !ok; i++) begin
         @(negedge clock);
         ok = (diagBusyFlag === 1'b0) && (ampStartRequest === 1'b0);
      end
   endtask
endmodule

// *** sld_startup_diag_tb_top.sv ***
`timescale 1ns/1ps
module sld_startup_diag_tb_top;
   logic            clock;
   logic            reset;
   logic            resultViewSelect;
   logic            supplyInvalid;
   logic            ampStartupDone;
   logic [3:0]      outputHigh, engineDisturb, openSense, boosterSense;
   logic [3:0]      shortedSense, supplySense, groundSense, bridgeInWindow;
   logic            diagEnableBit, ampStartEnableBit, statusRead;
   logic            diagBusyFlag, diagAborted, ampStartRequest, lineDriverMode;
   logic [1:0]      diagOffsetLevel;
   logic [3:0][7:0] channelStatusByte, expBytes;
   logic [3:0][7:0] expQ[$];
   logic            busyPrev, lineExp, ok;
   int              bad_count, samples_checked, seed, sel;

   sld_startup_diag #(.RAMP_CYCLES(8), .MEASURE_CYCLES(8)) sld_startup_diag_inst (
      .clock, .reset, .diagEnableBit, .ampStartEnableBit, .resultViewSelect, .statusRead,
      .supplyInvalid, .ampStartupDone, .outputHigh, .engineDisturb, .openSense,
      .boosterSense, .shortedSense, .supplySense, .groundSense, .bridgeInWindow,
      .diagBusyFlag, .diagAborted, .diagOffsetLevel, .ampStartRequest, .lineDriverMode,
      .channelStatusByte);
   sld_host_model sld_host_model_inst (.clock, .diagBusyFlag, .ampStartRequest,
      .diagEnableBit, .ampStartEnableBit, .statusRead);

   // ---------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_sig(input int which, input logic v);
      int n;
      n = 0;
      while ((which ? ampStartRequest : diagBusyFlag) !== v && n < 200) begin
         @(negedge clock);
         n++;
      end
      if (n == 200) begin
         bad_count++;
         $display("Error at %0t: wait timed out", $time);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // each finished cycle yields the oldest noted status bytes
   always @(negedge clock) begin
      if (reset === 1'b0 && busyPrev === 1'b1 && diagBusyFlag === 1'b0) begin
         if (expQ.size() == 0)
            check(1, 0);
         else
            check(channelStatusByte, expQ.pop_front());
      end
      busyPrev = diagBusyFlag;
   end
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // four cycles of at most about 30 clocks each, with ample margin
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      seed = 84139;
      {resultViewSelect, supplyInvalid, ampStartupDone} = 3'h0;
      {outputHigh, engineDisturb, openSense, boosterSense} = 16'h0;
      {shortedSense, supplySense, groundSense, bridgeInWindow} = 16'h0;
      reset = 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      check({diagBusyFlag, channelStatusByte}, {1'b0, 32'h30303030});
      lineExp = 1'b0;
      @(posedge clock);
      for (int c = 0; c < 4; c++) begin
         sel = $unsigned($random(seed)) % 4;
         boosterSense[c] <= (sel == 1);
         openSense[c] <= (sel == 2);
         engineDisturb[c] <= (sel == 3);
         expBytes[c] = {2'h0, sel[1:0], 4'h0};
         lineExp = lineExp | (sel == 1);
      end
      expQ.push_back(expBytes);
      sld_host_model_inst.set_bits(1'b1, 1'b0);
      wait_sig(0, 1'b1);
      check({diagOffsetLevel, channelStatusByte}, {sld_pkg::LEVEL_LOW, 32'h30303030});
      wait_sig(0, 1'b0);
      check({lineDriverMode, ampStartRequest}, {lineExp, 1'b0});
      check(diagOffsetLevel, sld_pkg::LEVEL_OFF);
      $display("test diag_only finished");
      @(posedge clock);
      resultViewSelect <= 1'b1;
      repeat (2) @(negedge clock);
      check(channelStatusByte, expBytes & 32'hcfcfcfcf);
      @(posedge clock);
      resultViewSelect <= 1'b0;
      repeat (2) @(negedge clock);
      check(channelStatusByte, expBytes);
      $display("test view_select finished");
      @(posedge clock);
      shortedSense <= 4'h1;
      supplySense <= 4'h2;
      groundSense <= 4'h8;
      sld_host_model_inst.bus_read();
      @(negedge clock);
      check(channelStatusByte, expBytes | 32'h0504060c);
      @(posedge clock);
      {shortedSense, supplySense, groundSense} <= 12'h0;
      bridgeInWindow <= 4'h4;
      repeat (3) @(negedge clock);
      check(channelStatusByte, expBytes | 32'h0500060c);
      @(posedge clock);
      bridgeInWindow <= 4'h0;
      sld_host_model_inst.bus_read();
      @(negedge clock);
      check(channelStatusByte, expBytes | 32'h04040404);
      $display("test status_read finished");
      sld_host_model_inst.set_bits(1'b0, 1'b0);
      sld_host_model_inst.set_bits(1'b1, 1'b0);
      wait_sig(0, 1'b1);
      check(channelStatusByte, 32'h34343434);
      @(posedge clock);
      reset <= 1'b1;
      sld_host_model_inst.set_bits(1'b0, 1'b0);
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      check({diagBusyFlag, channelStatusByte}, {1'b0, 32'h30303030});
      $display("test restart_and_reset finished");
      @(posedge clock);
      outputHigh <= 4'h2;
      expQ.push_back(32'h30303030);
      sld_host_model_inst.set_bits(1'b1, 1'b0);
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b0);
      check({diagAborted, ampStartRequest}, 2'b10);
      $display("test abort finished");
      @(posedge clock);
      {outputHigh, engineDisturb, openSense, boosterSense} <= 16'h0;
      expQ.push_back(32'h00000000);
      sld_host_model_inst.set_bits(1'b1, 1'b1);
      wait_sig(0, 1'b1);
      repeat (7) @(negedge clock);
      check(diagOffsetLevel, sld_pkg::LEVEL_LOW);
      @(negedge clock);
      check(diagOffsetLevel, sld_pkg::LEVEL_HIGH);
      wait_sig(1, 1'b1);
      check({diagBusyFlag, diagAborted}, 2'b10);
      @(posedge clock);
      ampStartupDone <= 1'b1;
      @(posedge clock);
      ampStartupDone <= 1'b0;
      wait_sig(0, 1'b0);
      sld_host_model_inst.set_bits(1'b1, 1'b0);
      sld_host_model_inst.wait_idle(ok);
      check({ok, expQ.size() == 0}, 2'b11);
      $display("test amp_start finished");
      report_and_stop();
   end
endmodule
